/* hdl/dcsr_map.svh */
// Purpose: offsets, field positions and reset values of the converter control registers
// Assumes: 7-bit register address from the serial configuration port decoder
// Notes:   definitions only
`ifndef DCSR_MAP_SVH
`define DCSR_MAP_SVH

`define DCSR_OFS_CTL2        7'h02
`define DCSR_OFS_CTL3        7'h03
`define DCSR_OFS_PATFAIL     7'h04

`define DCSR_RST_CTL2        16'h7000
`define DCSR_RST_CTL3        16'hf000
`define DCSR_RST_PATFAIL     16'h0000
`define DCSR_WMASK_CTL2      16'h70fa
`define DCSR_WMASK_CTL3      16'hf001

`define DCSR_B_DACCLK_SD     14
`define DCSR_B_DATACLK_SD    13
`define DCSR_B_COLL_SD       12
`define DCSR_B_FOUR_WIRE     7
`define DCSR_B_MIX_EN        6
`define DCSR_B_MIX_GAIN      5
`define DCSR_B_NCO_EN        4
`define DCSR_B_REVBUS        3
`define DCSR_B_TWOS          1
`define DCSR_B_SCALE_HI      15
`define DCSR_B_SCALE_LO      12
`define DCSR_B_TX_EN         0

`define DCSR_M_COLL          13
`define DCSR_M_DACCLK        10
`define DCSR_M_DATACLK       9
`define DCSR_M_OUTPUT        8

`define DCSR_MIDSCALE        16'h8000
`define DCSR_SIGN_FLIP       16'h8000

`endif

/* hdl/dcsr_pkg.sv */
// Purpose: types shared by the converter control register block
// Assumes: four 16-bit converter channels
// Notes:   constants live in dcsr_map.svh
package dcsr_pkg;

    typedef logic [15:0] dcsr_word_t;               // one register or sample word

    typedef struct packed {
        logic       we;                             // write strobe
        logic       re;                             // read strobe
        logic [6:0] addr;                           // register address
        dcsr_word_t wdata;                          // write data
    } dcsr_req_t;

    typedef struct packed {
        logic       four_wire;                      // serial port is 4-wire
        logic       mix_en;                         // mixing block on
        logic       mix_gain;                       // extra 6dB after mixer
        logic       nco_en;                         // oscillator running
        logic       rev_bus;                        // input bit order reversed
        logic       twos;                           // input is two's complement
        logic [4:0] scale_steps;                    // full-scale current in steps of 1..16
        logic       tx_en;                          // analog output transmitting
        logic       shutdown;                       // outputs forced to midscale
    } dcsr_ctl_t;

    typedef struct packed {
        dcsr_word_t           ctl2;                 // shutdown and format control
        dcsr_word_t           ctl3;                 // current scale and transmit
        dcsr_word_t           patfail;              // latched pattern failures
        dcsr_word_t           rdata;                // read answer
        logic                 rvalid;               // read answer valid
        logic                 tx_en;                // registered transmit enable
        logic                 shutdown;             // registered shutdown alarm
        logic [3:0][15:0]     chan;                 // output samples
    } dcsr_state_t;

endpackage

/* hdl/dcsr_regs.sv */
// Purpose: control and status registers of a quad converter, plus the sample conditioning they steer
// Assumes: register strobes come from the serial configuration port decoder, synchronous to CLK
// Notes:   every output but the scale step count is registered, one cycle behind its cause
// Notes on behaviour
// - converter clock loss shuts outputs when unmasked
// - input clock loss shuts outputs when unmasked
// - buffer collision shuts outputs when unmasked
// - select bit picks 4-wire or 3-wire port
// - mixer enabled only while its bit set
// - gain bit adds 6dB after mixer
// - oscillator runs only while its bit set
// - reversal bit swaps input bus bit order
// - format bit picks two's complement or offset
// - current scale field gives value plus one
// - transmit when register bit or pin high
// - result bit set on either bus failing
// - failure bits cleared by host write or reset only
// - shutdown drives midscale on every output
`timescale 1ns/1ps
`default_nettype none
`include "dcsr_map.svh"

module dcsr_regs (
    input  wire logic                   CLK,            // 250 MHz clock
    input  wire logic                   RST,            // async reset, high
    input  wire logic                   REG_WE,         // register write strobe
    input  wire logic                   REG_RE,         // register read strobe
    input  wire logic [6:0]             REG_ADDR,       // register address
    input  wire logic [15:0]            REG_WDATA,      // write data
    output logic      [15:0]            REG_RDATA,      // read data
    output logic                        REG_RVALID,     // read data valid pulse
    input  wire logic [15:0]            ALARM_MASK,     // alarm mask register contents
    input  wire logic                   DACCLK_LOST,    // converter clock lost level
    input  wire logic                   DATACLK_LOST,   // input data clock lost level
    input  wire logic                   COLLISION,      // buffer pointer collision level
    input  wire logic                   TX_ENABLE_PIN,  // transmit enable pin
    input  wire logic                   PAT_VALID,      // pattern check result valid
    input  wire logic [15:0]            PAT_FAIL_AB,    // failed bits on channel A/B bus
    input  wire logic [15:0]            PAT_FAIL_CD,    // failed bits on channel C/D bus
    input  wire logic [3:0][15:0]       SAMPLE_IN,      // input samples, four channels
    output logic      [3:0][15:0]       SAMPLE_OUT,     // offset-binary output codes
    output var dcsr_pkg::dcsr_ctl_t     CTL             // control levels to the datapath
);

    dcsr_pkg::dcsr_state_t  s_q;                        // all state
    dcsr_pkg::dcsr_state_t  s_d;                        // next state
    logic                   shut_cause;                 // combined unmasked shutdown cause
    logic                   out_mask;                   // combined output alarm masked
    logic [3:0][15:0]       rev_in;                     // bit-reversed inputs
    logic [3:0][15:0]       fmt_in;                     // inputs after order selection

    // bit reversal per channel and per bit
    for (genvar c = 0; c < 4; c++) begin : g_chan
        for (genvar b = 0; b < 16; b++) begin : g_bit
            assign rev_in[c][b] = SAMPLE_IN[c][15-b];
        end
        assign fmt_in[c] = s_q.ctl2[`DCSR_B_REVBUS] ? rev_in[c] : SAMPLE_IN[c];
    end

    // shutdown cause; the output-alarm mask blocks every path
    always_comb begin
        out_mask   = ALARM_MASK[`DCSR_M_OUTPUT];
        shut_cause = 1'b0;
        if (DACCLK_LOST && s_q.ctl2[`DCSR_B_DACCLK_SD] && !ALARM_MASK[`DCSR_M_DACCLK] && !out_mask) begin
            shut_cause = 1'b1;
        end
        if (DATACLK_LOST && s_q.ctl2[`DCSR_B_DATACLK_SD] && !ALARM_MASK[`DCSR_M_DATACLK] && !out_mask) begin
            shut_cause = 1'b1;
        end
        if (COLLISION && s_q.ctl2[`DCSR_B_COLL_SD] && !ALARM_MASK[`DCSR_M_COLL] && !out_mask) begin
            shut_cause = 1'b1;
        end
    end

    // next state: register writes, reads, status latching, sample path
    always_comb begin
        s_d        = s_q;
        s_d.rvalid = 1'b0;
        // writes keep only implemented bits
        if (REG_WE && REG_ADDR == `DCSR_OFS_CTL2) begin
            s_d.ctl2 = REG_WDATA & `DCSR_WMASK_CTL2;
        end
        if (REG_WE && REG_ADDR == `DCSR_OFS_CTL3) begin
            s_d.ctl3 = REG_WDATA & `DCSR_WMASK_CTL3;
        end
        // a write to the failure register clears the failures; a failure in the same cycle still lands
        if (REG_WE && REG_ADDR == `DCSR_OFS_PATFAIL) begin
            s_d.patfail = '0;
        end
        if (PAT_VALID) begin
            s_d.patfail = s_d.patfail | PAT_FAIL_AB | PAT_FAIL_CD;
        end
        // reads answer the next cycle; unmapped addresses read zero
        if (REG_RE) begin
            s_d.rvalid = 1'b1;
            case (REG_ADDR)
                `DCSR_OFS_CTL2:    s_d.rdata = s_q.ctl2;
                `DCSR_OFS_CTL3:    s_d.rdata = s_q.ctl3;
                `DCSR_OFS_PATFAIL: s_d.rdata = s_q.patfail;
                default:           s_d.rdata = '0;
            endcase
        end
        s_d.tx_en    = s_q.ctl3[`DCSR_B_TX_EN] | TX_ENABLE_PIN;
        s_d.shutdown = shut_cause;
        // offset binary out; a two's complement sample has its sign flipped
        for (int c = 0; c < 4; c++) begin
            if (shut_cause) begin
                s_d.chan[c] = `DCSR_MIDSCALE;
            end else if (s_q.ctl2[`DCSR_B_TWOS]) begin
                s_d.chan[c] = fmt_in[c] ^ `DCSR_SIGN_FLIP;
            end else begin
                s_d.chan[c] = fmt_in[c];
            end
        end
    end

    // single register stage; reset loads the map reset values, failure bits cleared to zero
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s_q         <= '0;
            s_q.ctl2    <= `DCSR_RST_CTL2;
            s_q.ctl3    <= `DCSR_RST_CTL3;
            s_q.patfail <= `DCSR_RST_PATFAIL;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops, the scale step count through an adder
    assign REG_RDATA         = s_q.rdata;
    assign REG_RVALID        = s_q.rvalid;
    assign SAMPLE_OUT        = s_q.chan;
    assign CTL.four_wire     = s_q.ctl2[`DCSR_B_FOUR_WIRE];
    assign CTL.mix_en        = s_q.ctl2[`DCSR_B_MIX_EN];
    assign CTL.mix_gain      = s_q.ctl2[`DCSR_B_MIX_GAIN];
    assign CTL.nco_en        = s_q.ctl2[`DCSR_B_NCO_EN];
    assign CTL.rev_bus       = s_q.ctl2[`DCSR_B_REVBUS];
    assign CTL.twos          = s_q.ctl2[`DCSR_B_TWOS];
    assign CTL.scale_steps   = {1'b0, s_q.ctl3[`DCSR_B_SCALE_HI:`DCSR_B_SCALE_LO]} + 5'h01;
    assign CTL.tx_en         = s_q.tx_en;
    assign CTL.shutdown      = s_q.shutdown;

    // checks beside the logic
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // shutdown path: an unmasked converter clock loss, then midscale on the two outer outputs
    sequence dacclk_cause_s;
        DACCLK_LOST && s_q.ctl2[`DCSR_B_DACCLK_SD] && !ALARM_MASK[`DCSR_M_DACCLK] && !ALARM_MASK[`DCSR_M_OUTPUT];
    endsequence
    sequence mid_out_s;
        CTL.shutdown && SAMPLE_OUT[0] == `DCSR_MIDSCALE && SAMPLE_OUT[3] == `DCSR_MIDSCALE;
    endsequence
    // any of the three causes with its own path open
    sequence unmasked_cause_s;
        !ALARM_MASK[`DCSR_M_OUTPUT]
        && ((DACCLK_LOST && s_q.ctl2[`DCSR_B_DACCLK_SD] && !ALARM_MASK[`DCSR_M_DACCLK])
            || (DATACLK_LOST && s_q.ctl2[`DCSR_B_DATACLK_SD] && !ALARM_MASK[`DCSR_M_DATACLK])
            || (COLLISION && s_q.ctl2[`DCSR_B_COLL_SD] && !ALARM_MASK[`DCSR_M_COLL]));
    endsequence
    // every channel, not only the outer two
    sequence all_mid_s;
        SAMPLE_OUT[0] == `DCSR_MIDSCALE && SAMPLE_OUT[1] == `DCSR_MIDSCALE
        && SAMPLE_OUT[2] == `DCSR_MIDSCALE && SAMPLE_OUT[3] == `DCSR_MIDSCALE;
    endsequence
    // read path: a strobe to no mapped register, then a zero answer
    sequence unmapped_read_s;
        REG_RE && REG_ADDR != `DCSR_OFS_CTL2 && REG_ADDR != `DCSR_OFS_CTL3 && REG_ADDR != `DCSR_OFS_PATFAIL;
    endsequence
    sequence zero_answer_s;
        REG_RVALID && REG_RDATA == 16'h0000;
    endsequence

    // alarm shutdown and its masks
    dacclk_shut_a:   assert property (dacclk_cause_s |=> mid_out_s)
                     else $error("clock loss did not shut outputs");
    dataclk_shut_a:  assert property (DATACLK_LOST && s_q.ctl2[`DCSR_B_DATACLK_SD] && !ALARM_MASK[`DCSR_M_DATACLK]
                                      && !ALARM_MASK[`DCSR_M_OUTPUT] |=> CTL.shutdown)
                     else $error("data clock loss did not shut outputs");
    coll_shut_a:     assert property (COLLISION && s_q.ctl2[`DCSR_B_COLL_SD] && !ALARM_MASK[`DCSR_M_COLL]
                                      && !ALARM_MASK[`DCSR_M_OUTPUT] |=> CTL.shutdown)
                     else $error("collision did not shut outputs");
    mask_block_a:    assert property (ALARM_MASK[`DCSR_M_OUTPUT] |=> !CTL.shutdown)
                     else $error("masked alarm shut outputs");
    all_mid_a:       assert property (unmasked_cause_s |=> all_mid_s)
                     else $error("a channel left midscale during shutdown");
    no_cause_a:      assert property (!DACCLK_LOST && !DATACLK_LOST && !COLLISION |=> !CTL.shutdown)
                     else $error("shutdown without a cause");
    // control fields follow the register writes
    ctl2_write_a:    assert property (REG_WE && REG_ADDR == `DCSR_OFS_CTL2 |=>
                                      CTL.four_wire == $past(REG_WDATA[`DCSR_B_FOUR_WIRE])
                                      && CTL.mix_en == $past(REG_WDATA[`DCSR_B_MIX_EN])
                                      && CTL.mix_gain == $past(REG_WDATA[`DCSR_B_MIX_GAIN])
                                      && CTL.nco_en == $past(REG_WDATA[`DCSR_B_NCO_EN]))
                     else $error("control write not applied");
    scale_a:         assert property (REG_WE && REG_ADDR == `DCSR_OFS_CTL3 |=>
                                      CTL.scale_steps == {1'b0, $past(REG_WDATA[`DCSR_B_SCALE_HI:`DCSR_B_SCALE_LO])} + 5'h01)
                     else $error("current scale wrong");
    tx_en_a:         assert property (##1 CTL.tx_en == ($past(s_q.ctl3[`DCSR_B_TX_EN]) || $past(TX_ENABLE_PIN)))
                     else $error("transmit enable wrong");
    // sample path: order and format; reset is sampled so the first edge after release is skipped
    rev_twos_a:      assert property (!DACCLK_LOST && !DATACLK_LOST && !COLLISION
                                      && s_q.ctl2[`DCSR_B_REVBUS] && s_q.ctl2[`DCSR_B_TWOS]
                                      |=> SAMPLE_OUT[1][0] == $past(SAMPLE_IN[1][15])
                                      && SAMPLE_OUT[1][15] == !$past(SAMPLE_IN[1][0]))
                     else $error("reversed two's complement sample wrong");
    plain_fmt_a:     assert property (!RST && !DACCLK_LOST && !DATACLK_LOST && !COLLISION
                                      && !s_q.ctl2[`DCSR_B_REVBUS] && !s_q.ctl2[`DCSR_B_TWOS]
                                      |=> SAMPLE_OUT[2] == $past(SAMPLE_IN[2]))
                     else $error("offset binary sample altered");
    // failure bits: set, hold, clear with set winning
    pat_set_a:       assert property (PAT_VALID |=> (s_q.patfail & $past(PAT_FAIL_AB | PAT_FAIL_CD))
                                      == $past(PAT_FAIL_AB | PAT_FAIL_CD))
                     else $error("pattern failure lost");
    pat_hold_a:      assert property (!REG_WE && !PAT_VALID |=> s_q.patfail == $past(s_q.patfail))
                     else $error("failure bits changed without cause");
    pat_clear_a:     assert property (REG_WE && REG_ADDR == `DCSR_OFS_PATFAIL |=>
                                      s_q.patfail == ($past(PAT_VALID) ? $past(PAT_FAIL_AB | PAT_FAIL_CD) : 16'h0000))
                     else $error("failure bits not cleared by write");
    // reserved and unmapped bits read as zero
    reserved_a:      assert property (REG_RVALID |-> (s_q.ctl2 & ~`DCSR_WMASK_CTL2) == 16'h0000
                                      && (s_q.ctl3 & ~`DCSR_WMASK_CTL3) == 16'h0000)
                     else $error("reserved bits set");
    unmapped_read_a: assert property (unmapped_read_s |=> zero_answer_s)
                     else $error("unmapped address answered nonzero");
    ctl2_read_a:     assert property (REG_RE && REG_ADDR == `DCSR_OFS_CTL2 |=> REG_RVALID
                                      && (REG_RDATA & ~`DCSR_WMASK_CTL2) == 16'h0000)
                     else $error("reserved bits read back set");

endmodule

`default_nettype wire

/* verification/dcsr_host.sv */
// Purpose: host model that drives the register strobe port
// Assumes: one strobe per access, changed just after a rising clk
// Notes:   address and data are inverted on release so stale values never look valid
`timescale 1ns/1ps
`default_nettype none
module dcsr_host (
    input  wire logic        clk,    // register clock
    output logic             we,     // write strobe
    output logic             re,     // read strobe
    output logic [6:0]       addr,   // register address
    output logic [15:0]      wdata,  // write data
    input  wire logic [15:0] rdata,  // read answer
    input  wire logic        rvalid  // read answer valid
);
    // idle bus from time zero
    initial begin
        {we, re, addr, wdata} = '0;
    end
    // one write, strobe high for a single edge
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk);
        {we, addr, wdata} <= {1'b1, a, d};
        @(posedge clk);
        {we, addr, wdata} <= {1'b0, ~a, ~d};
    endtask
    // one read; the answer is awaited for a bounded number of edges
    task automatic rd(input logic [6:0] a, output logic [15:0] d);
        @(posedge clk);
        {re, addr} <= {1'b1, a};
        @(posedge clk);
        {re, addr} <= {1'b0, ~a};
        #1;
        for (int n = 0; n < 4 && rvalid !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        d = rdata;
    endtask
    // failure bits reset to zero; the host clears them by a write
    task automatic clr_fail();
        wr(7'h04, 16'h0000);
    endtask
endmodule
`default_nettype wire

/* verification/dac_config_status_regs_bench.sv */
// Purpose: self-checking bench for the converter control register block
// Assumes: host model drives the strobe port; alarms, pins and samples are driven here
// Notes:   outputs are registered, so each check waits a few edges after its cause
`timescale 1ns/1ps
`default_nettype none
module dac_config_status_regs_bench;
    logic                 clk = 1'b0;        // 250 MHz clock
    logic                 rst = 1'b1;        // async reset
    logic                 we;                // write strobe
    logic                 re;                // read strobe
    logic [6:0]           addr;              // register address
    logic [15:0]          wdata;             // write data
    logic [15:0]          rdata;             // read answer
    logic                 rvalid;            // read answer valid
    logic [15:0]          mask = 16'h0000;   // alarm mask contents
    logic [2:0]           lost = 3'h0;       // dac clock, data clock, collision
    logic                 pin = 1'b0;        // transmit enable pin
    logic                 pv = 1'b0;         // pattern result valid
    logic [15:0]          fab = 16'h0000;    // failures on a/b bus
    logic [15:0]          fcd = 16'h0000;    // failures on c/d bus
    logic [3:0][15:0]     sin = {16'h0003, 16'h1234, 16'h8001, 16'hffff}; // input samples
    logic [3:0][15:0]     sout;              // output codes
    logic [2:0][15:0]     mb = {16'h2000, 16'h0200, 16'h0400}; // own mask bit per cause
    logic [15:0]          e;                 // expected sample
    dcsr_pkg::dcsr_ctl_t  ctl;               // control levels
    int                   n_fail = 0;        // mismatches
    int                   checks_done = 0;   // comparisons made

    // free-running clock
    always #2 clk = ~clk;

    dcsr_regs dut_u (.CLK(clk), .RST(rst), .REG_WE(we), .REG_RE(re), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_RDATA(rdata), .REG_RVALID(rvalid), .ALARM_MASK(mask), .DACCLK_LOST(lost[2]),
        .DATACLK_LOST(lost[1]), .COLLISION(lost[0]), .TX_ENABLE_PIN(pin), .PAT_VALID(pv),
        .PAT_FAIL_AB(fab), .PAT_FAIL_CD(fcd), .SAMPLE_IN(sin), .SAMPLE_OUT(sout), .CTL(ctl));
    dcsr_host host_u (.clk(clk), .we(we), .re(re), .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid));

    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // read one register and compare
    task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
        logic [15:0] v;
        host_u.rd(a, v);
        chk(v, exp);
    endtask
    // registered outputs lag their cause, give them time
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    // verdict, reached from the tests and the watchdog alike
    task automatic test_done();
        if (n_fail == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdchk(7'h02, 16'h7000);
        rdchk(7'h03, 16'hf000);
        chk({11'h000, ctl.scale_steps}, 16'h0010);
        host_u.wr(7'h02, 16'hffff);
        settle();
        rdchk(7'h02, 16'h70fa);
        chk({10'h000, ctl[12:7]}, 16'h003f);
        host_u.wr(7'h02, 16'h0000);
        settle();
        chk({10'h000, ctl[12:7]}, 16'h0000);
        rdchk(7'h05, 16'h0000);
        host_u.wr(7'h03, 16'hffff);
        rdchk(7'h03, 16'hf001);
        // scale field gives value plus one
        for (int i = 0; i < 16; i += 5) begin
            host_u.wr(7'h03, {4'(i), 12'h000});
            settle();
            chk({11'h000, ctl.scale_steps}, 16'(i + 1));
        end
        // every pin and register bit combination
        for (int i = 0; i < 4; i++) begin
            host_u.wr(7'h03, {15'h0000, i[1]});
            @(posedge clk);
            pin <= i[0];
            settle();
            chk({15'h0000, ctl.tx_en}, {15'h0000, |i[1:0]});
        end
        // bit reversal and format on each channel
        for (int i = 0; i < 4; i++) begin
            host_u.wr(7'h02, {12'h700, i[1], 1'b0, i[0], 1'b0});
            settle();
            for (int c = 0; c < 4; c++) begin
                e = {<<{sin[c]}};
                if (!i[1])
                    e = sin[c];
                chk(sout[c], e ^ {i[0], 15'h0000});
            end
        end
        // each cause: unmasked, own mask, output mask, enable cleared
        for (int k = 0; k < 3; k++) begin
            for (int m = 0; m < 4; m++) begin
                host_u.wr(7'h02, m == 3 ? 16'h7000 ^ (16'h4000 >> k) : 16'h7000);
                @(posedge clk);
                mask <= m == 1 ? mb[k] : (m == 2 ? 16'h0100 : 16'h0000);
                lost <= 3'h4 >> k;
                settle();
                chk({15'h0000, ctl.shutdown}, {15'h0000, m == 0});
                // midscale must reach every channel, not only the one whose cause fired
                for (int c = 0; c < 4; c++)
                    chk(sout[c], m == 0 ? 16'h8000 : sin[c]);
            end
        end
        @(posedge clk);
        lost <= 3'h0;
        host_u.clr_fail();
        @(posedge clk);
        {pv, fab, fcd} <= {1'b1, 16'h0101, 16'h8001};
        @(posedge clk);
        pv <= 1'b0;
        settle();
        rdchk(7'h04, 16'h8101);
        // clear and a new failure at the same edge: the new failure stays
        fork
            host_u.clr_fail();
            begin
                @(posedge clk);
                {pv, fab, fcd} <= {1'b1, 16'h0010, 16'h0000};
                @(posedge clk);
                pv <= 1'b0;
            end
        join
        rdchk(7'h04, 16'h0010);
        host_u.clr_fail();
        rdchk(7'h04, 16'h0000);
        test_done();
    end

    // watchdog, far beyond the under two hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        test_done();
    end
endmodule
`default_nettype wire
